// ===== hdl/svi_map.vh
// Purpose: register map and field positions of the undervoltage monitor
// Assumes: AXI4-Lite byte addresses, one aligned 32-bit word per register
// Notes:   offsets below are block-local
`ifndef SVI_MAP_VH
`define SVI_MAP_VH

`define SVI_OFF_STATUS    8'h00
`define SVI_OFF_CONFIG    8'h04
`define SVI_OFF_EVT_STAT  8'h08
`define SVI_OFF_EVT_CLR   8'h0c
`define SVI_OFF_EVT_EN    8'h10

`define SVI_CFG_PWRD      0
`define SVI_CFG_RSTD      1
`define SVI_CFG_STOP      2
`define SVI_CFG_TRIP      3
`define SVI_CFG_RESET     4'h0

`define SVI_STAT_FLAG     0
`define SVI_STAT_LOCK     1

`define SVI_EVT_FALL      0
`define SVI_EVT_RISE      1
`define SVI_EVT_RST       2
`define SVI_EVT_W         3

`define SVI_RESP_OKAY     2'b00
`define SVI_RESP_SLVERR   2'b10

`endif

// ===== hdl/svi_supply_voltage_inhibit_ctrl.v
// Purpose: control logic around a supply comparator: status flag and reset request
// Assumes: comparator outputs are synchronous to clk
// Notes:   stop and wait mode levels come from the system controller
//
// Behaviour
// R1: trip range select clear after reset
// R2: hold reset request until supply above rising
// R3: comparator drives software readable status flag
// R4: monitor enabled out of reset by default
// R5: power disable stops reset and status updates
// R6: reset disable blocks reset request, flag works
// R7: stop enable keeps monitor running in stop
// R8: trip range bit selects upper or lower threshold
// R9: both disables clear: reset below falling threshold
// R10: trip range select is write once
// R11: no interrupt request from monitor itself; evt_irq is raised from enabled event bits
// R12: active in wait mode, reset may end it
// R13: in stop active only if enabled there
// R14: flag set below falling, clear above rising
// R15: disabled monitor drops reset, holds flag
`timescale 1ns/1ps
`default_nettype none
`include "svi_map.vh"

module svi_supply_voltage_inhibit_ctrl (
	input  wire        clk,            // system clock, 100 MHz
	input  wire        rst_n,          // asynchronous reset, active low
	input  wire        below_falling,  // comparator: supply below falling threshold
	input  wire        above_rising,   // comparator: supply above rising threshold
	input  wire        stop_mode,      // device is in stop mode
	input  wire        wait_mode,      // device is in wait mode
	output wire        trip_range_sel, // selects the falling threshold range
	output reg         reset_request,  // system reset request
	output wire        evt_irq,        // level interrupt of the event status bits
	input  wire [7:0]  s_axi_awaddr,   // write address
	input  wire        s_axi_awvalid,  // write address valid
	output wire        s_axi_awready,  // write address ready
	input  wire [31:0] s_axi_wdata,    // write data
	input  wire [3:0]  s_axi_wstrb,    // write strobes
	input  wire        s_axi_wvalid,   // write data valid
	output wire        s_axi_wready,   // write data ready
	output reg  [1:0]  s_axi_bresp,    // write response
	output reg         s_axi_bvalid,   // write response valid
	input  wire        s_axi_bready,   // write response ready
	input  wire [7:0]  s_axi_araddr,   // read address
	input  wire        s_axi_arvalid,  // read address valid
	output wire        s_axi_arready,  // read address ready
	output reg  [31:0] s_axi_rdata,    // read data
	output reg  [1:0]  s_axi_rresp,    // read response
	output reg         s_axi_rvalid,   // read data valid
	input  wire        s_axi_rready    // read data ready
);

	reg         cfg_pwrd;      // monitor power disable
	reg         cfg_rstd;      // monitor reset disable
	reg         cfg_stop;      // monitor stop enable
	reg         cfg_trip;      // trip range select
	reg         trip_locked;   // trip range already written once
	reg         flag;          // below threshold flag
	reg  [2:0]  evt_stat;      // sticky event bits
	reg  [2:0]  evt_en;        // event enables
	reg  [7:0]  aw_addr;       // captured write address
	reg         aw_held;       // write address captured
	reg  [31:0] w_data;        // captured write data
	reg         w_strb0;       // byte lane 0 strobe
	reg         w_held;        // write data captured
	reg  [2:0]  evt_set;       // events this cycle
	reg  [2:0]  evt_clr;       // clears this cycle
	reg  [31:0] rd_word;       // read mux
	reg         rd_ok;         // read address mapped
	wire        active;        // monitor running
	wire        wr_fire;       // write performed this cycle
	wire        do_reset;      // reset condition
	reg         next_flag;     // flag after this edge
	reg         wr_ok;         // write address mapped
	wire [2:0]  next_evt_stat; // sticky event bits after this edge
	wire        low_hold;      // request held until supply recovers
	wire        cfg_wr;        // configuration word written
	wire        en_wr;         // event enable word written
	wire        clr_wr;        // event clear word written
	genvar      gi;            // event bit index

	// monitor runs unless powered down, or in stop without stop enable
	assign active = !cfg_pwrd && (!stop_mode || cfg_stop); // R5 R7 R13 R12
	// once requested, hold until the supply clears the rising threshold
	assign low_hold = reset_request && !above_rising; // R2
	// request below the falling threshold unless resets are disabled
	assign do_reset = active && !cfg_rstd && (below_falling || low_hold); // R9 R6
	// range select straight from its configuration bit
	assign trip_range_sel = cfg_trip; // R8

	// level interrupt from enabled sticky event bits
	assign evt_irq = |(evt_stat & evt_en);

	// write channel readies, address and data in either order
	assign s_axi_awready = !aw_held && !s_axi_bvalid;
	assign s_axi_wready  = !w_held && !s_axi_bvalid;
	// commit once both halves are held and no answer is pending
	assign wr_fire = aw_held && w_held && !s_axi_bvalid;

	// read address ready while no read answer is pending
	assign s_axi_arready = !s_axi_rvalid;

	// next flag: set below falling, clear above rising, else hold
	always @* begin
		next_flag = flag;
		if (active && below_falling) begin // R3 R14
			next_flag = 1'b1;
		end else if (active && above_rising) begin // R14
			next_flag = 1'b0;
		end
	end

	// status flag with hysteresis, frozen while inactive
	always @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			flag <= 1'b0;
		end else begin
			flag <= next_flag; // R15
		end
	end

	// reset request, dropped one edge after the monitor stops
	always @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			reset_request <= 1'b0;
		end else begin
			reset_request <= do_reset; // R15 R11
		end
	end

	// events: falling trip, rising recovery, reset issued
	always @* begin
		evt_set = 3'h0;
		evt_clr = 3'h0;
		evt_set[`SVI_EVT_FALL] = active && below_falling && !flag;
		evt_set[`SVI_EVT_RISE] = active && above_rising && flag;
		evt_set[`SVI_EVT_RST]  = do_reset && !reset_request;
		if (clr_wr) begin
			evt_clr = w_data[2:0];
		end
	end

	// sticky bits, one slice each; a set in the clearing cycle wins
	generate
		for (gi = 0; gi < `SVI_EVT_W; gi = gi + 1) begin : g_evt
			assign next_evt_stat[gi] = evt_set[gi] | (evt_stat[gi] & ~evt_clr[gi]);
		end
	endgenerate

	// event status register
	always @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			evt_stat <= 3'h0;
		end else begin
			evt_stat <= next_evt_stat;
		end
	end

	// write decode, only byte lane 0 carries fields
	assign cfg_wr = wr_fire && w_strb0 && (aw_addr == `SVI_OFF_CONFIG);
	assign en_wr  = wr_fire && w_strb0 && (aw_addr == `SVI_OFF_EVT_EN);
	assign clr_wr = wr_fire && w_strb0 && (aw_addr == `SVI_OFF_EVT_CLR);

	// write address check, read-only words take writes and ignore them
	always @* begin
		case (aw_addr)
		`SVI_OFF_STATUS: begin
			wr_ok = 1'b1;
		end
		`SVI_OFF_CONFIG: begin
			wr_ok = 1'b1;
		end
		`SVI_OFF_EVT_STAT: begin
			wr_ok = 1'b1;
		end
		`SVI_OFF_EVT_CLR: begin
			wr_ok = 1'b1;
		end
		`SVI_OFF_EVT_EN: begin
			wr_ok = 1'b1;
		end
		default: begin
			wr_ok = 1'b0;
		end
		endcase
	end

	// write channel capture and response
	always @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			aw_held <= 1'b0;
			w_held <= 1'b0;
			aw_addr <= 8'h00;
			w_data <= 32'h0;
			w_strb0 <= 1'b0;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= `SVI_RESP_OKAY;
		end else begin
			if (s_axi_awvalid && s_axi_awready) begin
				aw_addr <= s_axi_awaddr;
				aw_held <= 1'b1;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				w_data <= s_axi_wdata;
				w_strb0 <= s_axi_wstrb[0];
				w_held <= 1'b1;
			end
			if (s_axi_bvalid && s_axi_bready) begin
				s_axi_bvalid <= 1'b0;
			end
			// both halves held: commit and answer
			if (wr_fire) begin
				aw_held <= 1'b0;
				w_held <= 1'b0;
				s_axi_bvalid <= 1'b1;
				s_axi_bresp <= wr_ok ? `SVI_RESP_OKAY : `SVI_RESP_SLVERR;
			end
		end
	end

	// configuration word; defaults leave the monitor enabled
	always @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			cfg_pwrd <= 1'b0; // R4
			cfg_rstd <= 1'b0; // R4
			cfg_stop <= 1'b0;
			cfg_trip <= 1'b0; // R1
			trip_locked <= 1'b0;
		end else if (cfg_wr) begin
			cfg_pwrd <= w_data[`SVI_CFG_PWRD]; // R5
			cfg_rstd <= w_data[`SVI_CFG_RSTD]; // R6
			cfg_stop <= w_data[`SVI_CFG_STOP]; // R7
			trip_locked <= 1'b1;
			// range is fixed by the first write after reset, whatever its value
			if (!trip_locked) begin // R10
				cfg_trip <= w_data[`SVI_CFG_TRIP]; // R8
			end
		end
	end

	// event enable word
	always @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			evt_en <= 3'h0;
		end else if (en_wr) begin
			evt_en <= w_data[2:0];
		end
	end

	// read mux
	always @* begin
		rd_word = 32'h0;
		rd_ok = 1'b1;
		case (s_axi_araddr)
		`SVI_OFF_STATUS: begin
			rd_word[`SVI_STAT_FLAG] = flag; // R3
			rd_word[`SVI_STAT_LOCK] = trip_locked;
		end
		`SVI_OFF_CONFIG: begin
			rd_word[`SVI_CFG_PWRD] = cfg_pwrd;
			rd_word[`SVI_CFG_RSTD] = cfg_rstd;
			rd_word[`SVI_CFG_STOP] = cfg_stop;
			rd_word[`SVI_CFG_TRIP] = cfg_trip;
		end
		`SVI_OFF_EVT_STAT: begin
			rd_word[2:0] = evt_stat;
		end
		`SVI_OFF_EVT_EN: begin
			rd_word[2:0] = evt_en;
		end
		`SVI_OFF_EVT_CLR: begin
			// clear word is write-only and reads as zero
			rd_word = 32'h0;
		end
		default: begin
			rd_ok = 1'b0;
		end
		endcase
	end

	// read answer valid, raised when the address is taken
	always @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			s_axi_rvalid <= 1'b0;
		end else if (s_axi_arvalid && s_axi_arready) begin
			s_axi_rvalid <= 1'b1;
		end else if (s_axi_rvalid && s_axi_rready) begin
			s_axi_rvalid <= 1'b0;
		end
	end

	// read data and response, loaded when the address is taken
	always @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			s_axi_rdata <= 32'h0;
			s_axi_rresp <= `SVI_RESP_OKAY;
		end else if (s_axi_arvalid && s_axi_arready) begin
			s_axi_rdata <= rd_word;
			s_axi_rresp <= rd_ok ? `SVI_RESP_OKAY : `SVI_RESP_SLVERR;
		end
	end

	// wait mode needs no gating: the monitor simply keeps running there
	wire unused_wait = wait_mode; // R12

endmodule // svi_supply_voltage_inhibit_ctrl
`default_nettype wire

// ===== dv/svi_supply_model.sv
// Purpose: supply comparator seen by the monitor
// Assumes: lvl 0 below falling, 1 between, 2 above rising
// Notes:   between the thresholds both outputs stay low
`timescale 1ns/1ps
`default_nettype none
module svi_supply_model (
	input  wire logic [1:0] lvl,           // supply level code
	output logic            below_falling, // below falling threshold
	output logic            above_rising   // above rising threshold
);
	// threshold decode with hysteresis band in the middle
	assign below_falling = (lvl == 2'h0);
	assign above_rising  = (lvl == 2'h2);
endmodule // svi_supply_model
`default_nettype wire

// ===== dv/svi_ctrl_chk.sv
// Purpose: port checker for the undervoltage monitor
// Assumes: single clock domain, reset active low
// Notes:   bound to the design top from the bench
`timescale 1ns/1ps
`default_nettype none
module svi_ctrl_chk (
	input wire logic clk,            // clock
	input wire logic rst_n,          // reset
	input wire logic below_falling,  // low supply
	input wire logic reset_request,  // reset out
	input wire logic trip_range_sel, // range out
	input wire logic s_axi_awvalid,  // aw valid
	input wire logic s_axi_awready,  // aw ready
	input wire logic s_axi_wvalid,   // w valid
	input wire logic s_axi_wready,   // w ready
	input wire logic s_axi_bvalid,   // b valid
	input wire logic s_axi_bready,   // b ready
	input wire logic s_axi_arvalid,  // ar valid
	input wire logic s_axi_arready,  // ar ready
	input wire logic s_axi_rvalid,   // r valid
	input wire logic s_axi_rready    // r ready
);
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_n);
	// both write halves taken at one edge
	sequence wr_take;
		s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
	endsequence
	req_cause_a: assert property ($rose(reset_request) |-> $past(below_falling))
		else $error("reset request without low supply");
	trip_keep_a: assert property ($past(rst_n) |-> !$fell(trip_range_sel))
		else $error("trip range dropped");
	wr_time_a: assert property (wr_take |=> !s_axi_bvalid ##1 s_axi_bvalid)
		else $error("write answer late");
	rd_time_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
		else $error("read answer late");
	ar_block_a: assert property (s_axi_rvalid |-> !s_axi_arready)
		else $error("read taken while busy");
	aw_block_a: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
		else $error("write taken while busy");
	b_done_a: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
		else $error("write answer stuck");
	r_done_a: assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid)
		else $error("read answer stuck");
endmodule // svi_ctrl_chk
`default_nettype wire

// ===== dv/tb.sv
// Purpose: self-checking bench of the undervoltage monitor
// Assumes: comparator model drives the supply inputs
// Notes:   trip range is write-once, so modes get fresh resets
`timescale 1ns/1ps
`default_nettype none
module tb;
	logic clk, rst_n, stop_mode, wait_mode, below_falling, above_rising;
	logic trip_range_sel, reset_request, evt_irq;
	logic [1:0] lvl, s_axi_bresp, s_axi_rresp;
	logic [7:0] s_axi_awaddr, s_axi_araddr;
	logic [31:0] s_axi_wdata, s_axi_rdata;
	logic [3:0] s_axi_wstrb;
	logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
	logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
	int error_cnt, checks;
	svi_supply_voltage_inhibit_ctrl uut (.*);
	svi_supply_model cmp (.*);
	// clock
	initial clk = 1'b0;
	always #5 clk = ~clk;
	task check(input string n, input logic [31:0] s, input logic [31:0] e);
		checks++;
		if (s !== e) begin
			error_cnt++;
			$display("[ERR] %s exp %h got %h", n, e, s);
		end
	endtask
	task tick(input int n);
		repeat (n) @(posedge clk);
	endtask
	task complete_run;
		if (error_cnt == 0 && checks > 0) $display("Result: passed");
		else $display("Result: failed");
		$finish;
	endtask
	task wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
		@(posedge clk);
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		do begin
			@(posedge clk);
			if (s_axi_awready) s_axi_awvalid <= 1'b0;
			if (s_axi_wready) s_axi_wvalid <= 1'b0;
		end while (!s_axi_bvalid);
		s_axi_bready <= 1'b0;
		check("bresp", s_axi_bresp, r);
	endtask
	task rd(input logic [7:0] a, input logic [31:0] e, input logic [1:0] r);
		@(posedge clk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		do begin
			@(posedge clk);
			if (s_axi_arready) s_axi_arvalid <= 1'b0;
		end while (!s_axi_rvalid);
		s_axi_rready <= 1'b0;
		check("rdata", s_axi_rdata, e);
		check("rresp", s_axi_rresp, r);
	endtask
	task rst;
		rst_n <= 1'b0;
		lvl <= 2'h2;
		stop_mode <= 1'b0;
		wait_mode <= 1'b0;
		tick(8);
		rst_n <= 1'b1;
	endtask
	// set supply level and let the request settle
	task supply(input logic [1:0] l, input logic e);
		lvl <= l;
		tick(4);
		check("reset_request", reset_request, e);
	endtask
	task t_trip;
		rd(8'h04, 32'h0, 2'h0);
		check("trip_range_sel", trip_range_sel, 1'b0);
		supply(2'h0, 1'b1);
		rd(8'h00, 32'h1, 2'h0);
		supply(2'h1, 1'b1);
		rd(8'h00, 32'h1, 2'h0);
		supply(2'h2, 1'b0);
		rd(8'h00, 32'h0, 2'h0);
		rd(8'h08, 32'h7, 2'h0);
		wr(8'h10, 32'h7, 2'h0);
		check("evt_irq", evt_irq, 1'b1);
		wr(8'h0c, 32'h7, 2'h0);
		check("evt_irq", evt_irq, 1'b0);
	endtask
	task t_lock;
		wr(8'h04, 32'ha, 2'h0);
		check("trip_range_sel", trip_range_sel, 1'b1);
		wr(8'h04, 32'h2, 2'h0);
		rd(8'h04, 32'ha, 2'h0);
		supply(2'h0, 1'b0);
		rd(8'h00, 32'h3, 2'h0);
		rd(8'h20, 32'h0, 2'h2);
	endtask
	task t_modes;
		rst;
		check("trip_range_sel", trip_range_sel, 1'b0);
		wr(8'h04, 32'h1, 2'h0);
		supply(2'h0, 1'b0);
		rd(8'h00, 32'h2, 2'h0);
		rst;
		stop_mode <= 1'b1;
		supply(2'h0, 1'b0);
		rd(8'h00, 32'h0, 2'h0);
		stop_mode <= 1'b0;
		wait_mode <= 1'b1;
		supply(2'h0, 1'b1);
		rst;
		wr(8'h04, 32'h4, 2'h0);
		stop_mode <= 1'b1;
		supply(2'h0, 1'b1);
		wr(8'h04, 32'h5, 2'h0);
		supply(2'h0, 1'b0);
		rd(8'h00, 32'h3, 2'h0);
		supply(2'h2, 1'b0);
		rd(8'h00, 32'h3, 2'h0);
	endtask
	// main sequence
	initial begin
		{rst_n, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} <= '0;
		{stop_mode, wait_mode, s_axi_awaddr, s_axi_araddr, s_axi_wdata} <= '0;
		s_axi_wstrb <= 4'hf;
		lvl <= 2'h2;
		rst;
		t_trip;
		t_lock;
		t_modes;
		complete_run;
	end
	// watchdog against a hung handshake
	initial begin
		tick(5000);
		error_cnt++;
		complete_run;
	end
endmodule // tb
bind svi_supply_voltage_inhibit_ctrl svi_ctrl_chk chk (.*);
`default_nettype wire
